//--- rtl/ecp_defines.vh
// Constants for the extended-capabilities parallel port engine
// ============================================================
// Notes on behaviour
// - Strobe asserts so peripheral latches forward byte
// - Strobe interlocks with busy before next byte
// - Reverse byte valid handshaked by host acknowledge
// - Reverse acknowledge high data, low command
// - Forward host acknowledge high data, low command
// - Host acknowledge asserted requests one reverse byte
// - Reverse request low reverse, high forward
// - Fault edge raises error interrupt, forward only
// - Select-in held deasserted in extended mode
// - Address port sends commands, data port data
// - Leave 000/001 freely, otherwise return only there
// - Direction changes only in mode 001
// - Automatic handshake only in modes 011, 010
// - FIFO disabled after reset, threshold configurable
// - DMA request fills or drains FIFO per direction
// - Terminal count sets service flag, stops DMA
// - PIO data at 400H, address at 000H
// - PIO service requested through interrupt output
// - One shared sixteen-byte FIFO for all views
// - Three-bit mode field in extended control
// - Threshold sets service flag without DMA
`ifndef ECP_DEFINES_VH
`define ECP_DEFINES_VH
// ============================================================
// Register byte addresses
`define ECP_A_AFIFO 12'h000
`define ECP_A_DSR 12'h004
`define ECP_A_DCR 12'h008
`define ECP_A_DFIFO 12'h400
`define ECP_A_ECR 12'h408
`define ECP_A_THR 12'h40C
// ============================================================
// Mode codes
`define ECP_M_SPP 3'h0
`define ECP_M_PS2 3'h1
`define ECP_M_COMPAT_FIFO_PORT 3'h2
`define ECP_M_ECP 3'h3
`define ECP_M_TEST 3'h6
`define ECP_M_CNFG 3'h7
// ============================================================
// Field positions
`define ECP_DCR_STB 0
`define ECP_DCR_AFD 1
`define ECP_DCR_INIT 2
`define ECP_DCR_SLIN 3
`define ECP_DCR_DIR 5
`define ECP_ECR_MODE 7:5
`define ECP_ECR_NERR 4
`define ECP_ECR_DMA_ENABLE_BIT 3
`define ECP_ECR_SVC 2
// ============================================================
// Reset and fixed values
`define ECP_DCR_RST 8'h00
`define ECP_ECR_RST 8'h14
`define ECP_THR_RST 4'h8
`define ECP_CNFGA 8'h10
`define ECP_HI2 2'h3
`define ECP_HI3 3'h7
`endif

//--- rtl/ecp_port.v
// Extended-capabilities parallel port engine with APB registers and DMA
//
// Chosen here: the APB register port.
`default_nettype none
`include "ecp_defines.vh"

module ecp_port #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire dma_ack_in,
    input wire dma_tc_in,
    input wire [7:0] dma_wdata,
    output reg [7:0] dma_rdata,
    output reg port_dma_request,
    output reg irq,
    input wire [7:0] port_data_in,
    output reg [7:0] port_data_out,
    output reg port_data_oe,
    input wire periph_valid_in,
    input wire periph_acknowledge_in,
    input wire reverse_acknowledge_in,
    input wire fault_in,
    input wire printer_online_in,
    output reg host_strobe_out,
    output reg host_acknowledge_out,
    output reg reverse_request_out,
    output reg select_in_out
);

    // ============================================================
    // Helpers
    function fifo_mode;
        input [2:0] m;
        begin
            fifo_mode = (m == `ECP_M_COMPAT_FIFO_PORT) || (m == `ECP_M_ECP) || (m == `ECP_M_TEST);
        end
    endfunction

    function base_mode;
        input [2:0] m;
        begin
            base_mode = (m == `ECP_M_SPP) || (m == `ECP_M_PS2);
        end
    endfunction

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_SETUP = 5'h02;
    localparam [4:0] ST_STRB = 5'h04;
    localparam [4:0] ST_HOLD = 5'h08;
    localparam [4:0] ST_RACK = 5'h10;

    // ============================================================
    // Pin synchronisers, two stages before any use
    reg [12:0] pin_meta_ff;
    reg [12:0] pin_sync_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= 13'h1FFF;
            pin_sync_ff <= 13'h1FFF;
        end else begin
            pin_meta_ff <= {printer_online_in, fault_in, reverse_acknowledge_in,
                            periph_acknowledge_in, periph_valid_in, port_data_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end
    wire [7:0] pd_s = pin_sync_ff[7:0];
    wire valid_s = pin_sync_ff[8];
    wire busy_s = pin_sync_ff[9];
    wire revack_s = pin_sync_ff[10];
    wire fault_s = pin_sync_ff[11];
    wire online_s = pin_sync_ff[12];

    // ============================================================
    // Control registers
    reg [7:0] data_ff;
    reg [7:0] dcr_ff;
    reg [2:0] mode_ff;
    reg nerr_ff;
    reg dma_enable_bit_ff;
    reg svc_ff;
    reg [3:0] thr_ff;
    reg svc_evt_ff;
    reg flt_evt_ff;
    reg fault_d_ff;

    wire dir = dcr_ff[`ECP_DCR_DIR];
    wire ecp_m = (mode_ff == `ECP_M_ECP);
    wire fwd_run = (ecp_m && !dir) || (mode_ff == `ECP_M_COMPAT_FIFO_PORT);
    wire rev_run = ecp_m && dir;

    // APB: one wait cycle, act at the edge where pready is sampled high
    wire apb_acc = psel && penable;
    wire apb_done = apb_acc && pready;
    wire apb_wr = apb_done && pwrite;
    wire apb_rd = apb_done && !pwrite;
    wire a_afifo = (paddr == `ECP_A_AFIFO);
    wire a_dfifo = (paddr == `ECP_A_DFIFO);
    wire a_ecr = (paddr == `ECP_A_ECR);
    wire a_dcr = (paddr == `ECP_A_DCR);
    wire a_thr = (paddr == `ECP_A_THR);
    wire a_dsr = (paddr == `ECP_A_DSR);
    wire a_ok = a_afifo || a_dfifo || a_ecr || a_dcr || a_thr || a_dsr;

    // ============================================================
    // Shared FIFO, bit 8 tags a command byte
    reg [8:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_ff;
    reg [AW-1:0] rptr_ff;
    reg [AW:0] cnt_ff;
    wire [AW:0] depth_c = DEPTH[AW:0];
    wire f_empty = (cnt_ff == {(AW+1){1'b0}});
    wire f_full = (cnt_ff == depth_c);
    wire [8:0] head = mem[rptr_ff];
    wire [AW:0] free_c = depth_c - cnt_ff;
    wire [AW:0] thr_c = {1'b0, thr_ff};

    // Forward/reverse handshake state
    reg [4:0] st_ff;
    reg [4:0] nxt_st;
    reg strb_ff;
    reg nxt_strb;
    reg hack_ff;
    reg nxt_hack;
    reg [7:0] fdata_ff;
    reg [7:0] nxt_fdata;
    reg fsm_pop;
    reg fsm_push;

    // DMA moves bytes only in FIFO modes while enabled and not serviced
    wire dma_ok = dma_enable_bit_ff && !svc_ff && fifo_mode(mode_ff);
    wire dma_in = dma_ok && dma_ack_in && !dir;
    wire dma_out = dma_ok && dma_ack_in && dir && !f_empty;

    // PIO: address port carries commands, data port carries data
    wire pio_cmd = apb_wr && a_afifo && ecp_m && !dir;
    wire pio_dat = apb_wr && a_dfifo && (fwd_run || mode_ff == `ECP_M_TEST);
    wire pio_rd = apb_rd && a_dfifo && (rev_run || mode_ff == `ECP_M_TEST) && !f_empty;

    // One push and one pop per cycle; hardware sources first
    reg push;
    reg [8:0] push_d;
    reg pop;
    always @* begin
        push = 1'b0;
        push_d = 9'h000;
        if (fsm_push) begin
            push = 1'b1;
            push_d = {~busy_s, pd_s};
        end else if (dma_in) begin
            push = 1'b1;
            push_d = {1'b0, dma_wdata};
        end else if (pio_cmd || pio_dat) begin
            push = 1'b1;
            push_d = {pio_cmd, pwdata[7:0]};
        end
        push = push && !f_full;
        pop = (fsm_pop || dma_out || pio_rd) && !f_empty;
    end

    // FIFO held in reset outside FIFO modes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else if (!fifo_mode(mode_ff)) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wptr_ff <= wptr_ff + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rptr_ff <= rptr_ff + {{(AW-1){1'b0}}, 1'b1};
            if (push && !pop)
                cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
            else if (pop && !push)
                cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
        end
    end

    // Storage has no reset
    always @(posedge pclk) begin
        if (push)
            mem[wptr_ff] <= push_d;
    end

    // ============================================================
    // Handshake engine
    always @* begin
        nxt_st = st_ff;
        nxt_strb = strb_ff;
        nxt_hack = hack_ff;
        nxt_fdata = fdata_ff;
        fsm_pop = 1'b0;
        fsm_push = 1'b0;
        case (st_ff)
            ST_IDLE: begin
                nxt_strb = 1'b1;
                if (fwd_run) begin
                    nxt_hack = 1'b1;
                    // Peripheral not busy and link turned forward
                    if (!f_empty && !busy_s && revack_s) begin
                        nxt_fdata = head[7:0];
                        nxt_hack = ecp_m ? ~head[8] : 1'b1;
                        nxt_st = ST_SETUP;
                    end
                end else if (rev_run) begin
                    // Request a byte only while room remains
                    nxt_hack = f_full || revack_s;
                    if (!valid_s && !hack_ff) begin
                        fsm_push = 1'b1;
                        nxt_hack = 1'b1;
                        nxt_st = ST_RACK;
                    end
                end else begin
                    nxt_hack = 1'b1;
                end
            end
            ST_SETUP: begin
                nxt_strb = 1'b0;
                nxt_st = ST_STRB;
            end
            ST_STRB: begin
                if (busy_s) begin
                    nxt_strb = 1'b1;
                    fsm_pop = 1'b1;
                    nxt_st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!busy_s)
                    nxt_st = ST_IDLE;
            end
            ST_RACK: begin
                if (valid_s) begin
                    nxt_hack = 1'b1;
                    nxt_st = ST_IDLE;
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
        // Leaving the handshake modes aborts any transfer
        if (!fwd_run && !rev_run) begin
            nxt_st = ST_IDLE;
            nxt_strb = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_IDLE;
            strb_ff <= 1'b1;
            hack_ff <= 1'b1;
            fdata_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            strb_ff <= nxt_strb;
            hack_ff <= nxt_hack;
            fdata_ff <= nxt_fdata;
        end
    end

    // ============================================================
    // Register writes, mode and service flag
    wire [2:0] wr_mode = pwdata[`ECP_ECR_MODE];
    wire mode_wr_ok = base_mode(mode_ff) || base_mode(wr_mode);
    wire fault_edge = fault_d_ff && !fault_s;
    wire thr_hit = dir ? (cnt_ff >= thr_c) : (free_c >= thr_c);
    wire svc_set = !svc_ff && fifo_mode(mode_ff) &&
                   (dma_enable_bit_ff ? (dma_tc_in && dma_ok) : thr_hit);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= 8'h00;
            dcr_ff <= `ECP_DCR_RST;
            mode_ff <= `ECP_M_SPP;
            nerr_ff <= 1'b1;
            dma_enable_bit_ff <= 1'b0;
            svc_ff <= 1'b1;
            thr_ff <= `ECP_THR_RST;
            svc_evt_ff <= 1'b0;
            flt_evt_ff <= 1'b0;
            fault_d_ff <= 1'b1;
        end else begin
            fault_d_ff <= fault_s;
            if (apb_wr && a_afifo && base_mode(mode_ff))
                data_ff <= pwdata[7:0];
            if (apb_wr && a_dcr) begin
                dcr_ff[4:0] <= pwdata[4:0];
                if (mode_ff == `ECP_M_PS2)
                    dcr_ff[`ECP_DCR_DIR] <= pwdata[`ECP_DCR_DIR];
            end
            if (apb_wr && a_thr)
                thr_ff <= pwdata[3:0];
            if (apb_wr && a_ecr) begin
                if (mode_wr_ok)
                    mode_ff <= wr_mode;
                nerr_ff <= pwdata[`ECP_ECR_NERR];
                dma_enable_bit_ff <= pwdata[`ECP_ECR_DMA_ENABLE_BIT];
            end
            // Hardware set beats a software clear in the same cycle
            if (svc_set)
                svc_ff <= 1'b1;
            else if (apb_wr && a_ecr)
                svc_ff <= pwdata[`ECP_ECR_SVC];
            if (svc_set)
                svc_evt_ff <= 1'b1;
            else if (apb_wr && a_ecr)
                svc_evt_ff <= 1'b0;
            // Fault counts as an error only while running forward
            if (fault_edge && ecp_m && !dir && !nerr_ff)
                flt_evt_ff <= 1'b1;
            else if (apb_wr && a_ecr)
                flt_evt_ff <= 1'b0;
        end
    end

    // ============================================================
    // Read mux
    reg [31:0] rd_c;
    always @* begin
        rd_c = 32'h0000_0000;
        if (a_afifo)
            rd_c[7:0] = (mode_ff == `ECP_M_PS2) ? pd_s : data_ff;
        else if (a_dsr)
            rd_c[7:0] = {~busy_s, valid_s, revack_s, online_s, fault_s, `ECP_HI3};
        else if (a_dcr)
            rd_c[7:0] = {`ECP_HI2, dcr_ff[5:0]};
        else if (a_dfifo)
            rd_c[8:0] = (mode_ff == `ECP_M_CNFG) ? {1'b0, `ECP_CNFGA} : head;
        else if (a_ecr)
            rd_c[7:0] = {mode_ff, nerr_ff, dma_enable_bit_ff, svc_ff, f_full, f_empty};
        else if (a_thr)
            rd_c[3:0] = thr_ff;
    end

    // ============================================================
    // Registered outputs: bus, DMA, interrupt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            dma_rdata <= 8'h00;
            port_dma_request <= 1'b0;
            irq <= 1'b0;
        end else begin
            pready <= apb_acc && !pready;
            pslverr <= apb_acc && !pready && !a_ok;
            if (apb_acc && !pready)
                prdata <= rd_c;
            if (dma_out)
                dma_rdata <= head[7:0];
            // Request drops in the cycle after each acknowledge cycle
            port_dma_request <= dma_ok && !dma_ack_in && !svc_set &&
                                (dir ? !f_empty : !f_full);
            irq <= svc_evt_ff || flt_evt_ff;
        end
    end

    // ============================================================
    // Registered pin outputs
    reg nxt_stb_p;
    reg nxt_afd_p;
    reg nxt_init_p;
    reg nxt_slin_p;
    reg [7:0] nxt_pd;
    reg nxt_oe;
    always @* begin
        nxt_stb_p = ~dcr_ff[`ECP_DCR_STB];
        nxt_afd_p = ~dcr_ff[`ECP_DCR_AFD];
        nxt_init_p = dcr_ff[`ECP_DCR_INIT];
        nxt_slin_p = ~dcr_ff[`ECP_DCR_SLIN];
        nxt_pd = data_ff;
        nxt_oe = !(mode_ff == `ECP_M_PS2 && dir);
        if (mode_ff == `ECP_M_COMPAT_FIFO_PORT) begin
            nxt_stb_p = strb_ff;
            nxt_pd = fdata_ff;
        end else if (ecp_m) begin
            nxt_stb_p = strb_ff;
            nxt_afd_p = hack_ff;
            nxt_init_p = !dir;
            nxt_slin_p = 1'b1;
            nxt_pd = fdata_ff;
            nxt_oe = !dir && revack_s;
        end else if (mode_ff == `ECP_M_TEST) begin
            nxt_pd = head[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_strobe_out <= 1'b1;
            host_acknowledge_out <= 1'b1;
            reverse_request_out <= 1'b0;
            select_in_out <= 1'b1;
            port_data_out <= 8'h00;
            port_data_oe <= 1'b0;
        end else begin
            host_strobe_out <= nxt_stb_p;
            host_acknowledge_out <= nxt_afd_p;
            reverse_request_out <= nxt_init_p;
            select_in_out <= nxt_slin_p;
            port_data_out <= nxt_pd;
            port_data_oe <= nxt_oe;
        end
    end

endmodule // ecp_port
`default_nettype wire

//--- sim/ecp_port_checker.sv
// Pin-level protocol checks for the parallel port engine
`default_nettype none
module ecp_port_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic dma_ack_in,
    input wire logic dma_tc_in,
    input wire logic port_dma_request,
    input wire logic irq,
    input wire logic [7:0] port_data_out,
    input wire logic port_data_oe,
    input wire logic periph_valid_in,
    input wire logic periph_acknowledge_in,
    input wire logic reverse_acknowledge_in,
    input wire logic host_strobe_out,
    input wire logic host_acknowledge_out
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ============================================================
    // Register bus
    property p_one_wait;
        psel && penable && !$past(penable) |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
    // ============================================================
    // Link and DMA
    property p_oe_off;
        !periph_valid_in |-> !port_data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus fight");
    property p_strobe_data;
        !host_strobe_out |-> $stable(port_data_out);
    endproperty
    a_strobe_data: assert property (p_strobe_data) else $error("data moved");
    property p_strobe_hold;
        $fell(host_strobe_out) ##0 (!periph_acknowledge_in) [*4] |-> !host_strobe_out;
    endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("strobe early");
    property p_dma_drop;
        port_dma_request && dma_ack_in |=> !port_dma_request;
    endproperty
    a_dma_drop: assert property (p_dma_drop) else $error("request held");
    property p_tc_irq;
        port_dma_request && dma_tc_in |-> ##[1:3] (irq && !port_dma_request);
    endproperty
    a_tc_irq: assert property (p_tc_irq) else $error("no tc irq");
    property p_rev_ack;
        !reverse_acknowledge_in && $fell(periph_valid_in) |-> ##[1:6] host_acknowledge_out;
    endproperty
    a_rev_ack: assert property (p_rev_ack) else $error("no host ack");
    c_dma: cover property (port_dma_request && dma_ack_in);
    c_fwd: cover property ($fell(host_strobe_out));
    c_rev: cover property ($fell(periph_valid_in));
endmodule // ecp_port_checker

bind ecp_port ecp_port_checker ecp_port_checker_i (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .dma_ack_in, .dma_tc_in,
    .port_dma_request, .irq, .port_data_out, .port_data_oe, .periph_valid_in,
    .periph_acknowledge_in, .reverse_acknowledge_in, .host_strobe_out, .host_acknowledge_out
);
`default_nettype wire

//--- sim/ecp_printer_model.sv
// Behavioural extended-mode printer on the far side of the port
`default_nettype none
module ecp_printer_model (
    input wire logic lclk,
    input wire logic slow,
    input wire logic host_strobe_out,
    input wire logic host_acknowledge_out,
    input wire logic reverse_request_out,
    input wire logic [7:0] port_data_out,
    output logic periph_valid_in,
    output logic periph_acknowledge_in,
    output logic reverse_acknowledge_in,
    output logic [7:0] pd_drive
);
    logic [8:0] rx_q[$];
    logic [8:0] tx_q[$];
    logic [1:0] st_ff = 2'h0;
    logic [1:0] gap_ff = 2'h0;
    initial begin
        periph_valid_in = 1'b1;
        periph_acknowledge_in = 1'b0;
        reverse_acknowledge_in = 1'b1;
        pd_drive = 8'h00;
    end
    // ============================================================
    // Handshakes, stepped by the link clock
    always @(posedge lclk) begin
        reverse_acknowledge_in <= reverse_request_out;
        gap_ff <= gap_ff + 2'h1;
        if (reverse_acknowledge_in) begin
            // Slow mode only takes a byte every fourth link cycle
            if (!host_strobe_out && !periph_acknowledge_in && (!slow || gap_ff == 2'h3)) begin
                rx_q.push_back({~host_acknowledge_out, port_data_out});
                periph_acknowledge_in <= 1'b1;
            end else if (host_strobe_out) begin
                periph_acknowledge_in <= 1'b0;
            end
        end else begin
            case (st_ff)
                2'h0: if (!host_acknowledge_out && tx_q.size() > 0) begin
                    pd_drive <= tx_q[0][7:0];
                    periph_acknowledge_in <= ~tx_q[0][8];
                    st_ff <= 2'h1;
                end
                2'h1: begin
                    periph_valid_in <= 1'b0;
                    st_ff <= 2'h2;
                end
                2'h2: if (host_acknowledge_out) begin
                    periph_valid_in <= 1'b1;
                    void'(tx_q.pop_front());
                    st_ff <= 2'h3;
                end
                default: if (!host_acknowledge_out) begin
                    pd_drive <= ~pd_drive; // Released lines never show the old byte
                    st_ff <= 2'h0;
                end
            endcase
        end
    end
endmodule // ecp_printer_model
`default_nettype wire

//--- sim/ecp_port_tb.sv
// Self-checking bench for the extended parallel port engine
`default_nettype none
`include "ecp_defines.vh"
module ecp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic lclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, rerr, slow;
    logic dma_ack_in, dma_tc_in, port_dma_request, irq, port_data_oe, fault_in;
    logic host_strobe_out, host_acknowledge_out, reverse_request_out, select_in_out;
    logic periph_valid_in, periph_acknowledge_in, reverse_acknowledge_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] dma_wdata, port_data_out, pd_drive;
    wire [7:0] port_data_in;
    int errors = 0;
    int checked = 0;
    // Pin level: the device when enabled, else the printer
    assign port_data_in = port_data_oe ? port_data_out : pd_drive;
    always #4 pclk = ~pclk;
    always #80 lclk = ~lclk;
    ecp_port ecp_port_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .dma_ack_in, .dma_tc_in, .dma_wdata, .dma_rdata(), .port_dma_request,
        .irq, .port_data_in, .port_data_out, .port_data_oe, .periph_valid_in,
        .periph_acknowledge_in, .reverse_acknowledge_in, .fault_in,
        .printer_online_in(1'b1), .host_strobe_out, .host_acknowledge_out,
        .reverse_request_out, .select_in_out
    );
    ecp_printer_model prt_i (
        .lclk, .slow, .host_strobe_out, .host_acknowledge_out, .reverse_request_out,
        .port_data_out, .periph_valid_in, .periph_acknowledge_in, .reverse_acknowledge_in,
        .pd_drive
    );
    // ============================================================
    // Shared tasks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask
    task automatic wait_rx(input int n);
        int k;
        k = 0;
        while (prt_i.rx_q.size() < n && k < 3000) begin
            @(posedge pclk);
            k++;
        end
    endtask
    // Sees the request one edge late, so a just-served ack is never repeated
    task automatic dma(input logic tc, input logic [7:0] b);
        int k;
        k = 0;
        do @(posedge pclk); while (port_dma_request !== 1'b1 && ++k < 300);
        dma_wdata <= b;
        dma_ack_in <= !tc;
        dma_tc_in <= tc;
        @(posedge pclk);
        dma_ack_in <= 1'b0;
        dma_tc_in <= 1'b0;
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset();
        apb(1'b0, `ECP_A_ECR, 32'h0);
        chk("ecr", 9'h015, {1'b0, rdat[7:0]});
        apb(1'b0, `ECP_A_THR, 32'h0);
        chk("thr", 9'h008, {5'h00, rdat[3:0]});
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 9'h001, {8'h00, rerr});
        $display("t_reset done");
    endtask
    task automatic t_modes();
        apb(1'b1, `ECP_A_DCR, 32'h20);
        apb(1'b0, `ECP_A_DCR, 32'h0);
        chk("dir_in_000", 9'h000, {8'h00, rdat[5]});
        apb(1'b1, `ECP_A_ECR, 32'h74);
        apb(1'b1, `ECP_A_ECR, 32'hD4);
        apb(1'b0, `ECP_A_ECR, 32'h0);
        chk("mode_kept", 9'h003, {6'h00, rdat[7:5]});
        apb(1'b1, `ECP_A_ECR, 32'h34);
        apb(1'b1, `ECP_A_ECR, 32'hD4);
        apb(1'b0, `ECP_A_ECR, 32'h0);
        chk("mode_test", 9'h006, {6'h00, rdat[7:5]});
        apb(1'b1, `ECP_A_ECR, 32'h14);
        $display("t_modes done");
    endtask
    task automatic t_fwd();
        slow = 1'b1;
        apb(1'b1, `ECP_A_DCR, 32'h04);
        apb(1'b1, `ECP_A_ECR, 32'h74);
        chk("rev_req_fwd", 9'h001, {8'h00, reverse_request_out});
        apb(1'b1, `ECP_A_AFIFO, 32'h83);
        apb(1'b1, `ECP_A_DFIFO, 32'hA5);
        apb(1'b1, `ECP_A_DFIFO, 32'h3C);
        wait_rx(3);
        chk("fwd_cmd", 9'h183, prt_i.rx_q[0]);
        chk("fwd_dat", 9'h0A5, prt_i.rx_q[1]);
        chk("fwd_order", 9'h03C, prt_i.rx_q[2]);
        chk("sel_in", 9'h001, {8'h00, select_in_out});
        apb(1'b1, `ECP_A_ECR, 32'h64);
        fault_in <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("flt_irq", 9'h001, {8'h00, irq});
        fault_in <= 1'b1;
        apb(1'b1, `ECP_A_ECR, 32'h70);
        repeat (4) @(posedge pclk);
        chk("thr_irq", 9'h001, {8'h00, irq});
        prt_i.rx_q.delete();
        $display("t_fwd done");
    endtask
    task automatic t_dma();
        slow = 1'b0;
        apb(1'b1, `ECP_A_ECR, 32'h68);
        dma(1'b0, 8'h10);
        dma(1'b0, 8'h11);
        dma(1'b1, 8'h00);
        repeat (4) @(posedge pclk);
        chk("tc_irq", 9'h001, {8'h00, irq});
        chk("tc_req", 9'h000, {8'h00, port_dma_request});
        wait_rx(2);
        chk("dma_b0", 9'h010, prt_i.rx_q[0]);
        chk("dma_b1", 9'h011, prt_i.rx_q[1]);
        apb(1'b1, `ECP_A_ECR, 32'h74);
        prt_i.rx_q.delete();
        $display("t_dma done");
    endtask
    task automatic t_rev();
        int k;
        k = 0;
        apb(1'b1, `ECP_A_ECR, 32'h34);
        apb(1'b1, `ECP_A_DCR, 32'h20);
        apb(1'b1, `ECP_A_ECR, 32'h74);
        prt_i.tx_q.push_back(9'h042);
        prt_i.tx_q.push_back(9'h11F);
        while ((prt_i.tx_q.size() > 0 || prt_i.st_ff != 2'h0) && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        chk("rev_req", 9'h000, {8'h00, reverse_request_out});
        chk("oe_rev", 9'h000, {8'h00, port_data_oe});
        apb(1'b0, `ECP_A_DFIFO, 32'h0);
        chk("rev_dat", 9'h042, rdat[8:0]);
        apb(1'b0, `ECP_A_DFIFO, 32'h0);
        chk("rev_cmd", 9'h11F, rdat[8:0]);
        $display("t_rev done");
    endtask
    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ============================================================
    // Main sequence and watchdog
    initial begin
        {presetn, psel, penable, pwrite, slow, dma_ack_in, dma_tc_in} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        dma_wdata = 8'h00;
        fault_in = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_fwd();
        t_dma();
        t_rev();
        summarize();
    end
    initial begin
        #300000;
        errors++;
        summarize();
    end
endmodule // ecp_port_tb
`default_nettype wire
